// [src/fpll_device.sv]
// Synthesizer control end: serial registers, divider words, slip reduction, fastlock.
`timescale 1ns/100ps
`include "fpll_params.svh"
module fpll_device (
  // Clock is the comparison clock; reset is synchronous.
  input wire logic clk,
  input wire logic nrst,
  // Programming link.
  fpll_if.device link,
  // Cycle slip detector inputs, one comparison cycle per pulse.
  input wire logic slip_imminent,
  input wire logic tune_up,
  input wire logic freq_passed,
  // Divider settings toward the analog core.
  output logic [11:0] int_value,
  output logic [24:0] fraction_word,
  output logic [36:0] feedback_ratio,
  output logic [1:0] comparison_mult,
  output logic [6:0] comparison_div,
  output logic reference_halving,
  // Charge pump controls.
  output logic [3:0] cp_setting,
  output logic [4:0] cp_gain,
  output logic [6:0] cell_source_en,
  output logic [6:0] cell_sink_en,
  // Loop bandwidth state.
  output logic wide_bw
);
  // Serial capture.
  fpll_pkg::fpll_word_type shift, next_shift;
  logic sclk_q, le_q;
  // Programmed registers.
  fpll_pkg::fpll_word_type reg_intfrac, reg_lsb, reg_rdiv, reg_func, reg_test;
  fpll_pkg::fpll_word_type next_intfrac, next_lsb, next_rdiv, next_func, next_test;
  logic latch_int, next_latch_int;
  // Slip reduction state.
  logic [2:0] cells, next_cells;
  logic dir_up, next_dir_up;
  logic unwind, next_unwind;
  // Derived values.
  logic [5:0] r_factor;
  logic slip_on;
  logic [11:0] timer_load;
  logic timer_start;
  logic [11:0] timer_count;
  logic mux_fast;
  logic [6:0] thermo;
  // Registered outputs.
  logic [24:0] next_fraction_word;
  logic [36:0] next_ratio;
  logic [6:0] next_src, next_snk;
  logic [6:0] next_div;
  logic next_mux_oe;
  logic next_wide;

  // Shift on the serial clock rising edge, load the word on the latch rising edge.
  always_comb begin
    next_shift = shift;
    next_intfrac = reg_intfrac;
    next_lsb = reg_lsb;
    next_rdiv = reg_rdiv;
    next_func = reg_func;
    next_test = reg_test;
    next_latch_int = 1'b0;
    if (link.sclk && !sclk_q) begin
      next_shift = {shift[30:0], link.sdata};
    end
    if (link.le && !le_q) begin
      unique case (shift[`FPLL_SEL_HI:`FPLL_SEL_LO])
        `FPLL_SEL_INTFRAC: begin
          next_intfrac = shift;
          next_latch_int = 1'b1;
        end
        `FPLL_SEL_LSBFRAC: begin
          next_lsb = shift;
        end
        `FPLL_SEL_RDIV: begin
          next_rdiv = shift;
        end
        `FPLL_SEL_FUNC: begin
          next_func = shift;
        end
        `FPLL_SEL_TEST: begin
          next_test = shift;
        end
        default: begin
          // Codes above four select nothing here and are dropped.
          next_shift = shift;
        end
      endcase
    end
  end

  // Serial registers; all programmed values clear at reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift <= 32'h0000_0000;
      sclk_q <= 1'b0;
      le_q <= 1'b0;
      reg_intfrac <= 32'h0000_0000;
      reg_lsb <= 32'h0000_0000;
      reg_rdiv <= 32'h0000_0000;
      reg_func <= 32'h0000_0000;
      reg_test <= 32'h0000_0000;
      latch_int <= 1'b0;
    end else begin
      shift <= next_shift;
      sclk_q <= link.sclk;
      le_q <= link.le;
      reg_intfrac <= next_intfrac;
      reg_lsb <= next_lsb;
      reg_rdiv <= next_rdiv;
      reg_func <= next_func;
      reg_test <= next_test;
      latch_int <= next_latch_int;
    end
  end

  // Divider words. A zero R field stands for the largest ratio of 32.
  always_comb begin
    next_fraction_word = {reg_intfrac[`FPLL_FMSB_HI:`FPLL_FMSB_LO],
                 reg_lsb[`FPLL_FLSB_HI:`FPLL_FLSB_LO]};
    next_ratio = {reg_intfrac[`FPLL_INT_HI:`FPLL_INT_LO], next_fraction_word};
    if (reg_rdiv[`FPLL_RCNT_HI:`FPLL_RCNT_LO] == 5'h00) begin
      r_factor = `FPLL_RCNT_FULL;
    end else begin
      r_factor = {1'b0, reg_rdiv[`FPLL_RCNT_HI:`FPLL_RCNT_LO]};
    end
    next_div = reg_rdiv[`FPLL_HALF_BIT] ? {r_factor, 1'b0} : {1'b0, r_factor};
  end

  // Slip reduction cell controller. The count saturates rather than wraps,
  // because a wrap would drop all cells at the worst moment of the pull-in.
  assign slip_on = reg_rdiv[`FPLL_CSR_BIT];
  always_comb begin
    next_cells = cells;
    next_dir_up = dir_up;
    next_unwind = unwind;
    thermo = 7'h00;
    if (!slip_on) begin
      next_cells = 3'h0;
      next_unwind = 1'b0;
    end else if (unwind) begin
      // Overshoot seen: shed one cell per comparison cycle.
      if (cells != 3'h0) begin
        next_cells = cells - 3'h1;
      end else begin
        next_unwind = 1'b0;
      end
    end else if (freq_passed && cells != 3'h0) begin
      next_unwind = 1'b1;
    end else if (slip_imminent) begin
      if (cells == 3'h0) begin
        next_dir_up = tune_up;
      end
      if (cells != `FPLL_MAX_CELLS) begin
        next_cells = cells + 3'h1;
      end
    end
    for (int i = 0; i < 7; i++) begin
      thermo[i] = (3'(i) < next_cells);
    end
    next_src = next_dir_up ? thermo : 7'h00;
    next_snk = next_dir_up ? 7'h00 : thermo;
  end

  // Fastlock starts on each integer register latch when mode 01 is armed.
  assign timer_load = reg_test[`FPLL_TIMER_HI:`FPLL_TIMER_LO];
  assign timer_start = latch_int &&
    (reg_test[`FPLL_CKMODE_HI:`FPLL_CKMODE_LO] == `FPLL_CKMODE_FAST);

  // The timer counts comparison cycles, which is the rate of this clock.
  fpll_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(timer_start),
    .load(timer_load),
    .active(wide_bw),
    .count(timer_count)
  );

  // The pin is pulled low only in the fastlock switch selection.
  assign mux_fast = (reg_intfrac[`FPLL_MUX_HI:`FPLL_MUX_LO] == `FPLL_MUX_FASTLOCK);
  // Next timer level: a reload wins over a running window, so a zero reload
  // drops the pump gain and the pin in the same cycle as the timer level.
  always_comb begin
    next_wide = timer_start ? (timer_load != 12'h000) :
                (wide_bw && timer_count != 12'h001);
    next_mux_oe = mux_fast && next_wide;
  end

  // Output registers, aligned with the timer level.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cells <= 3'h0;
      dir_up <= 1'b0;
      unwind <= 1'b0;
      int_value <= 12'h000;
      fraction_word <= 25'h0000000;
      feedback_ratio <= 37'h0000000000;
      comparison_mult <= 2'h1;
      comparison_div <= 7'h20;
      reference_halving <= 1'b0;
      cp_setting <= 4'h0;
      cp_gain <= `FPLL_CP_GAIN_NORM;
      cell_source_en <= 7'h00;
      cell_sink_en <= 7'h00;
      link.mux_oe <= 1'b0;
      link.mux_out <= 1'b0;
    end else begin
      cells <= next_cells;
      dir_up <= next_dir_up;
      unwind <= next_unwind;
      int_value <= reg_intfrac[`FPLL_INT_HI:`FPLL_INT_LO];
      fraction_word <= next_fraction_word;
      feedback_ratio <= next_ratio;
      comparison_mult <= reg_rdiv[`FPLL_DBL_BIT] ? 2'h2 : 2'h1;
      comparison_div <= next_div;
      reference_halving <= reg_rdiv[`FPLL_HALF_BIT];
      cp_setting <= reg_rdiv[`FPLL_CP_HI:`FPLL_CP_LO];
      cp_gain <= next_wide ? `FPLL_CP_GAIN_WIDE : `FPLL_CP_GAIN_NORM;
      cell_source_en <= next_src;
      cell_sink_en <= next_snk;
      link.mux_oe <= next_mux_oe;
      link.mux_out <= 1'b0;
    end
  end
endmodule // fpll_device

// [src/fpll_params.svh]
// Numeric constants shared by both ends of the synthesizer control link.
`ifndef FPLL_PARAMS_SVH
`define FPLL_PARAMS_SVH
// Register select codes held in the three control bits of each word.
`define FPLL_SEL_HI 2
`define FPLL_SEL_LO 0
`define FPLL_SEL_INTFRAC 3'h0
`define FPLL_SEL_LSBFRAC 3'h1
`define FPLL_SEL_RDIV 3'h2
`define FPLL_SEL_FUNC 3'h3
`define FPLL_SEL_TEST 3'h4
// Integer/fraction register fields.
`define FPLL_INT_HI 26
`define FPLL_INT_LO 15
`define FPLL_FMSB_HI 14
`define FPLL_FMSB_LO 3
`define FPLL_MUX_HI 30
`define FPLL_MUX_LO 27
`define FPLL_MUX_FASTLOCK 4'hc
// Lower fraction register field.
`define FPLL_FLSB_HI 27
`define FPLL_FLSB_LO 15
`define FPLL_FLSB_BITS 13
// Reference divider register fields.
`define FPLL_CSR_BIT 28
`define FPLL_CP_HI 27
`define FPLL_CP_LO 24
`define FPLL_HALF_BIT 21
`define FPLL_DBL_BIT 20
`define FPLL_RCNT_HI 19
`define FPLL_RCNT_LO 15
`define FPLL_RCNT_FULL 6'h20
// Function register field.
`define FPLL_POL_BIT 6
// Test register fields.
`define FPLL_CKMODE_HI 20
`define FPLL_CKMODE_LO 19
`define FPLL_CKMODE_FAST 2'h1
`define FPLL_TIMER_HI 18
`define FPLL_TIMER_LO 7
// Slip reduction limits and fastlock gains.
`define FPLL_MAX_CELLS 3'h7
`define FPLL_CP_GAIN_WIDE 5'h10
`define FPLL_CP_GAIN_NORM 5'h01
// Comparison frequency ceiling in kHz and serial clock half period in clocks less one.
`define FPLL_PFD_MAX_KHZ 32000
`define FPLL_SCLK_HALF 4'h4
`define FPLL_WORD_BITS 32
`endif

// [src/fpll_pkg.sv]
// Types shared by the two ends of the synthesizer control link.
package fpll_pkg;
  // Host serial sender states.
  typedef enum logic [2:0] {
    FPLL_IDLE,
    FPLL_LOW,
    FPLL_HIGH,
    FPLL_LATCH,
    FPLL_GAP
  } fpll_host_state_type;
  // One serial word.
  typedef logic [31:0] fpll_word_type;
endpackage

// [src/fpll_if.sv]
// Three-wire programming link plus the multiplexed output pin.
`timescale 1ns/100ps
interface fpll_if;
  logic sclk; // Serial clock, data taken on its rising edge.
  logic sdata; // Serial data, most significant bit first.
  logic le; // Latch enable, rising edge loads the shifted word.
  logic mux_out; // Multiplexed output pin value driven by the device.
  logic mux_oe; // High while the device drives the multiplexed output pin.
  // Programming side.
  modport host (output sclk, output sdata, output le, input mux_out, input mux_oe);
  // Synthesizer side.
  modport device (input sclk, input sdata, input le, output mux_out, output mux_oe);
endinterface

// [src/fpll_timer.sv]
// Down counter that holds a level for a loaded number of comparison cycles.
`timescale 1ns/100ps
module fpll_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Load request.
  input wire logic start,
  input wire logic [11:0] load,
  // Timer state.
  output logic active,
  output logic [11:0] count
);
  logic [11:0] next_count;
  logic next_active;

  // A zero load never raises the level, so no wide window appears.
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = load;
    end else if (count != 12'h000) begin
      next_count = count - 12'h001;
    end
    next_active = (next_count != 12'h000);
  end

  // Level and count change together, so the level lasts exactly load cycles.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= 12'h000;
      active <= 1'b0;
    end else begin
      count <= next_count;
      active <= next_active;
    end
  end
endmodule // fpll_timer

// [src/fpll_host.sv]
// Programming end: checks each word, keeps power-up order, shifts it out serially.
`timescale 1ns/100ps
`include "fpll_params.svh"
module fpll_host #(
  parameter int REF_KHZ = 10000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Word request from software.
  input wire logic wr_valid,
  input wire logic [31:0] wr_word,
  output logic wr_ready,
  // Status.
  output logic init_done,
  output logic refused,
  // Programming link.
  fpll_if.host link
);
  fpll_pkg::fpll_host_state_type state, next_state;
  fpll_pkg::fpll_word_type word, next_word;
  logic [4:0] bits, next_bits;
  logic [3:0] tick, next_tick;
  logic [2:0] expect_sel, next_expect;
  logic next_init, next_refused, pol_pos, next_pol;
  logic next_sclk, next_sdata, next_le;
  logic [2:0] sel;
  logic [5:0] r_factor;
  logic [31:0] lhs, rhs;
  logic bad;

  // Settings checks on the offered word.
  always_comb begin
    sel = wr_word[`FPLL_SEL_HI:`FPLL_SEL_LO];
    if (wr_word[`FPLL_RCNT_HI:`FPLL_RCNT_LO] == 5'h00) begin
      r_factor = `FPLL_RCNT_FULL;
    end else begin
      r_factor = {1'b0, wr_word[`FPLL_RCNT_HI:`FPLL_RCNT_LO]};
    end
    lhs = 32'(REF_KHZ) * (wr_word[`FPLL_DBL_BIT] ? 32'h2 : 32'h1);
    rhs = 32'(`FPLL_PFD_MAX_KHZ) * 32'(r_factor) *
          (wr_word[`FPLL_HALF_BIT] ? 32'h2 : 32'h1);
    bad = 1'b0;
    if (!init_done && sel != expect_sel) begin
      bad = 1'b1;
    end
    if (sel == `FPLL_SEL_RDIV) begin
      if (lhs > rhs) begin
        bad = 1'b1;
      end
      if (wr_word[`FPLL_CSR_BIT] && (!pol_pos || !wr_word[`FPLL_HALF_BIT])) begin
        bad = 1'b1;
      end
    end
  end

  // Sender: the serial clock is a divided copy of clk, one bit per period.
  always_comb begin
    next_state = state;
    next_word = word;
    next_bits = bits;
    next_tick = (tick == 4'h0) ? 4'h0 : tick - 4'h1;
    next_expect = expect_sel;
    next_init = init_done;
    next_pol = pol_pos;
    next_refused = 1'b0;
    next_sclk = link.sclk;
    next_sdata = link.sdata;
    next_le = 1'b0;
    unique case (state)
      fpll_pkg::FPLL_IDLE: begin
        if (wr_valid && bad) begin
          next_refused = 1'b1;
        end else if (wr_valid) begin
          next_word = wr_word;
          next_bits = 5'h1f;
          next_sdata = wr_word[31];
          next_sclk = 1'b0;
          next_tick = `FPLL_SCLK_HALF;
          next_state = fpll_pkg::FPLL_LOW;
          if (sel == `FPLL_SEL_FUNC) begin
            next_pol = wr_word[`FPLL_POL_BIT];
          end
          if (!init_done) begin
            next_init = (sel == `FPLL_SEL_INTFRAC);
            next_expect = expect_sel - 3'h1;
          end
        end
      end
      fpll_pkg::FPLL_LOW: begin
        if (tick == 4'h0) begin
          next_sclk = 1'b1;
          next_tick = `FPLL_SCLK_HALF;
          next_state = fpll_pkg::FPLL_HIGH;
        end
      end
      fpll_pkg::FPLL_HIGH: begin
        if (tick == 4'h0) begin
          next_sclk = 1'b0;
          next_tick = `FPLL_SCLK_HALF;
          if (bits == 5'h00) begin
            next_state = fpll_pkg::FPLL_LATCH;
          end else begin
            next_bits = bits - 5'h01;
            next_word = {word[30:0], 1'b0};
            next_sdata = word[30];
            next_state = fpll_pkg::FPLL_LOW;
          end
        end
      end
      fpll_pkg::FPLL_LATCH: begin
        next_le = 1'b1;
        if (tick == 4'h0) begin
          next_le = 1'b0;
          next_tick = `FPLL_SCLK_HALF;
          next_state = fpll_pkg::FPLL_GAP;
        end
      end
      fpll_pkg::FPLL_GAP: begin
        if (tick == 4'h0) begin
          next_state = fpll_pkg::FPLL_IDLE;
        end
      end
    endcase
  end

  // Registers; the order tracker starts at the test register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= fpll_pkg::FPLL_IDLE;
      word <= 32'h0000_0000;
      bits <= 5'h00;
      tick <= 4'h0;
      expect_sel <= `FPLL_SEL_TEST;
      init_done <= 1'b0;
      pol_pos <= 1'b0;
      refused <= 1'b0;
      wr_ready <= 1'b0;
      link.sclk <= 1'b0;
      link.sdata <= 1'b0;
      link.le <= 1'b0;
    end else begin
      state <= next_state;
      word <= next_word;
      bits <= next_bits;
      tick <= next_tick;
      expect_sel <= next_expect;
      init_done <= next_init;
      pol_pos <= next_pol;
      refused <= next_refused;
      wr_ready <= (next_state == fpll_pkg::FPLL_IDLE);
      link.sclk <= next_sclk;
      link.sdata <= next_sdata;
      link.le <= next_le;
    end
  end
endmodule // fpll_host

// [verif/fpll_checker.sv]
// Concurrent checks on the programming link and the loop control outputs.
`timescale 1ns/100ps
module fpll_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Programming link.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic le,
  input wire logic mux_out,
  input wire logic mux_oe,
  // Loop control outputs.
  input wire logic wide_bw,
  input wire logic [4:0] cp_gain,
  input wire logic [6:0] cell_source_en,
  input wire logic [6:0] cell_sink_en
);
  // All checks share the comparison clock and sleep while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // The latch pulse stands four clocks and then drops.
  sequence latch_frame;
    le [*4] ##1 !le;
  endsequence
  // A serial clock high phase stands five clocks and then drops.
  sequence sclk_high_phase;
    sclk [*5] ##1 !sclk;
  endsequence
  latch_width_a: assert property ($rose(le) |-> latch_frame)
    else $error("latch pulse has the wrong width");
  serial_high_a: assert property ($rose(sclk) |-> sclk_high_phase)
    else $error("serial clock high phase has the wrong width");
  latch_quiet_a: assert property (le |-> !sclk)
    else $error("serial clock toggles during the latch pulse");
  // Data may not move while the device could still be sampling it.
  shift_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("serial data changed while the serial clock was high");
  pump_gain_a: assert property (cp_gain == (wide_bw ? 5'h10 : 5'h01))
    else $error("pump gain does not follow the bandwidth state");
  pin_ground_a: assert property (mux_oe |-> !mux_out && wide_bw)
    else $error("output pin driven outside wide bandwidth or not low");
  // Wide bandwidth may only open right after a word was latched.
  wide_cause_a: assert property ($rose(wide_bw) |-> $past(le, 2))
    else $error("wide bandwidth started without a latched word");
  one_way_a: assert property (!((|cell_source_en) && (|cell_sink_en)))
    else $error("extra cells source and sink at once");
  cell_step_a: assert property ($countones(cell_source_en | cell_sink_en) <=
    $countones($past(cell_source_en | cell_sink_en)) + 1)
    else $error("more than one extra cell switched on in one cycle");
endmodule // fpll_checker

// [verif/tb_fracn_pll_lock_control.sv]
// Self-checking bench joining the programming end to the synthesizer end.
`timescale 1ns/100ps
module tb_fracn_pll_lock_control;
  // One row: word offered, refused or not, init state after, wide cycles seen.
  typedef struct {
    logic [31:0] word;
    logic refd;
    logic init;
    int wide;
  } fpll_row_type;
  logic clk;
  logic nrst;
  logic wr_valid;
  logic [31:0] wr_word;
  logic wr_ready;
  logic init_done;
  logic refused;
  logic slip_imminent;
  logic tune_up;
  logic freq_passed;
  logic [11:0] int_value;
  logic [24:0] fraction_word;
  logic [36:0] feedback_ratio;
  logic [1:0] comparison_mult;
  logic [6:0] comparison_div;
  logic reference_halving;
  logic [3:0] cp_setting;
  logic [4:0] cp_gain;
  logic [6:0] cell_source_en;
  logic [6:0] cell_sink_en;
  logic wide_bw;
  int bad_count;
  int compares;
  int wide_cycles;
  int pin_cycles;
  int base;
  int pins;
  fpll_row_type rows [12];
  logic [31:0] tw [3];
  int te [3];
  fpll_if link();
  // A doubled 20 MHz reference makes the comparison limit reachable.
  fpll_host #(.REF_KHZ(20000)) i_fpll_host (.clk(clk), .nrst(nrst), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_ready(wr_ready), .init_done(init_done), .refused(refused),
    .link(link));
  fpll_device i_fpll_device (.clk(clk), .nrst(nrst), .link(link),
    .slip_imminent(slip_imminent), .tune_up(tune_up), .freq_passed(freq_passed),
    .int_value(int_value), .fraction_word(fraction_word), .feedback_ratio(feedback_ratio),
    .comparison_mult(comparison_mult), .comparison_div(comparison_div),
    .reference_halving(reference_halving), .cp_setting(cp_setting), .cp_gain(cp_gain),
    .cell_source_en(cell_source_en), .cell_sink_en(cell_sink_en), .wide_bw(wide_bw));
  fpll_checker i_fpll_checker (.clk(clk), .nrst(nrst), .sclk(link.sclk),
    .sdata(link.sdata), .le(link.le), .mux_out(link.mux_out), .mux_oe(link.mux_oe),
    .wide_bw(wide_bw), .cp_gain(cp_gain), .cell_source_en(cell_source_en),
    .cell_sink_en(cell_sink_en));
  // The 50 ns comparison clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts wide bandwidth and pin drive cycles at the quiet edge.
  always @(negedge clk) begin
    if (wide_bw === 1'b1) wide_cycles++;
    if (link.mux_oe === 1'b1) pin_cycles++;
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits, bounded, for the host to be idle; called at a falling edge.
  task automatic wait_ready();
    int n;
    n = 0;
    while (wr_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk("wr_ready", 37'h1, wr_ready);
  endtask
  // Offers one word; valid is held only up to the edge that takes it.
  // The refusal pulse stands only in the cycle after that edge, so it is looked at there.
  task automatic send(input logic [31:0] w, input logic exp_ref);
    wait_ready();
    wr_valid = 1'b1;
    wr_word = w;
    @(negedge clk);
    chk("refused", exp_ref, refused);
    wr_valid = 1'b0;
    @(negedge clk);
    wait_ready();
  endtask
  // Pulses the slip detector n times, one comparison cycle each.
  task automatic slips(input int n);
    repeat (n) begin
      slip_imminent = 1'b1;
      @(negedge clk);
      slip_imminent = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cuts a hang short; the whole run needs far fewer cycles than this.
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    wr_valid = 1'b0;
    wr_word = 32'h0000_0000;
    slip_imminent = 1'b0;
    tune_up = 1'b1;
    freq_passed = 1'b0;
    // Power-up order with slips in it, then the refusal cases of the divider word.
    rows = '{'{32'h0000_0000, 1'b1, 1'b0, 0}, '{32'h0008_0284, 1'b0, 1'b0, 0},
      '{32'h1331_0002, 1'b1, 1'b0, 0}, '{32'h0000_0043, 1'b0, 1'b0, 0},
      '{32'h1331_0002, 1'b0, 1'b0, 0}, '{32'h0eb8_8001, 1'b0, 1'b0, 0},
      '{32'h6122_0288, 1'b0, 1'b1, 5}, '{32'h0010_8002, 1'b1, 1'b1, 0},
      '{32'h1001_0002, 1'b1, 1'b1, 0}, '{32'h0000_0003, 1'b0, 1'b1, 0},
      '{32'h1331_0002, 1'b1, 1'b1, 0}, '{32'h0000_0043, 1'b0, 1'b1, 0}};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      base = wide_cycles;
      pins = pin_cycles;
      send(rows[i].word, rows[i].refd);
      chk("init_done", rows[i].init, init_done);
      chk("wide", rows[i].wide, wide_cycles - base);
      chk("pin", rows[i].wide, pin_cycles - pins);
    end
    // Refused words must not have disturbed the programmed dividers.
    chk("int", 37'h244, int_value);
    chk("fraction_word", 37'h0a3d71, fraction_word);
    chk("ratio", {12'h244, 25'h0a3d71}, feedback_ratio);
    chk("mult", 37'h2, comparison_mult);
    chk("div", 37'h4, comparison_div);
    chk("half", 37'h1, reference_halving);
    chk("cp", 37'h3, cp_setting);
    // Slip reduction is enabled here: add, saturate, unwind, then the other direction.
    slips(1);
    chk("src1", 37'h01, cell_source_en);
    slips(7);
    chk("src7", 37'h7f, cell_source_en);
    freq_passed = 1'b1;
    @(negedge clk);
    freq_passed = 1'b0;
    repeat (10) @(negedge clk);
    chk("unwound", 37'h0, cell_source_en);
    tune_up = 1'b0;
    slips(1);
    chk("sink1", 37'h01, cell_sink_en);
    send(32'h0020_0002, 1'b0);
    chk("sink_off", 37'h0, cell_sink_en);
    chk("div_r0", 37'h40, comparison_div);
    slips(2);
    chk("no_cells", 37'h0, cell_sink_en | cell_source_en);
    // Timer zero, timer one, and a timer with the mode field off.
    tw = '{32'h0008_0004, 32'h0008_0084, 32'h0000_0284};
    te = '{0, 1, 0};
    for (int i = 0; i < 3; i++) begin
      send(tw[i], 1'b0);
      base = wide_cycles;
      pins = pin_cycles;
      send(32'h0122_0288, 1'b0);
      chk("timer", te[i], wide_cycles - base);
      chk("no_pin", 37'h0, pin_cycles - pins);
    end
    // A second reset mid-run returns both ends to their reset state.
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk("rst_init", 37'h0, init_done);
    chk("rst_ready", 37'h0, wr_ready);
    chk("rst_div", 37'h20, comparison_div);
    chk("rst_mult", 37'h1, comparison_mult);
    chk("rst_gain", 37'h01, cp_gain);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    send(32'h0122_0288, 1'b1);
    finish_test();
  end
endmodule // tb_fracn_pll_lock_control
